// ---- display_hw_reset_sequencer.sv ----
// Hardware reset pin filter and reset-cancel sequencer
`timescale 1ns/100ps
module display_hw_reset_sequencer
   import rst_seq_pkg::*;
#(
   parameter int unsigned LOW_THR    = LOW_THR_CYC,
   parameter int unsigned GLITCH     = GLITCH_CYC,
   parameter int unsigned CANCEL_IN  = CANCEL_IN_CYC,
   parameter int unsigned CANCEL_OUT = CANCEL_OUT_CYC,
   parameter int unsigned BLANK      = BLANK_CYC,
   parameter int unsigned LOAD       = LOAD_CYC
) (
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   // Reset pin from host
   input  wire logic hw_reset_in_n_i,
   // Device state
   input  wire logic sleep_out_i,
   // Sequencer outputs
   output logic      core_reset_o,
   output logic      blank_o,
   output logic      nvm_load_o,
   output logic      cancel_busy_o,
   output logic      ready_o
);
   logic             pin_s1_q;
   logic             pin_s2_q;
   logic             filt_low_q;
   logic [CNT_W-1:0] glitch_q;
   logic [CNT_W-1:0] low_cnt_q;
   logic [CNT_W-1:0] tmr_q;
   logic [CNT_W-1:0] cancel_lim_q;
   logic [CNT_W-1:0] cancel_cnt_q;
   logic             was_out_q;
   seq_state_t       st_q;

   // Two flops before any logic reads the pin
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pin_s1_q <= 1'b1;
         pin_s2_q <= 1'b1;
      end else begin
         pin_s1_q <= hw_reset_in_n_i;
         pin_s2_q <= pin_s1_q;
      end
   end

   // glitch hold filter
   // Short highs inside a low pulse are bridged so the low count survives
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         filt_low_q <= 1'b0;
         glitch_q   <= '0;
      end else if (!pin_s2_q) begin
         filt_low_q <= 1'b1;
         glitch_q   <= '0;
      end else if (filt_low_q) begin
         if (glitch_q >= CNT_W'(GLITCH)) begin
            filt_low_q <= 1'b0;
            glitch_q   <= '0;
         end else begin
            glitch_q <= glitch_q + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         low_cnt_q <= '0;
      end else if (!filt_low_q) begin
         low_cnt_q <= '0;
      end else if (low_cnt_q < CNT_W'(LOW_THR)) begin
         low_cnt_q <= low_cnt_q + 1'b1;
      end
   end

   wire accept = filt_low_q && (low_cnt_q >= CNT_W'(LOW_THR));

   // Cancel ends early enough to cover the pin filter delay
   wire [CNT_W-1:0] cancel_end = cancel_lim_q - CNT_W'(GLITCH + 6);
   wire [CNT_W-1:0] load_start = cancel_end - CNT_W'(LOAD + 2);

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         cancel_cnt_q <= '0;
      end else if (st_q == ST_RUN || st_q == ST_LOW) begin
         cancel_cnt_q <= '0;
      end else if (cancel_cnt_q < cancel_lim_q) begin
         cancel_cnt_q <= cancel_cnt_q + 1'b1;
      end
   end

   // Sequencer
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         st_q         <= ST_RUN;
         tmr_q        <= '0;
         was_out_q    <= 1'b0;
         cancel_lim_q <= '0;
      end else begin
         case (st_q)
            ST_RUN: begin
               tmr_q <= '0;
               if (accept) begin
                  was_out_q <= sleep_out_i;
                  st_q      <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (tmr_q < CNT_W'(BLANK)) tmr_q <= tmr_q + 1'b1;
               if (!filt_low_q) begin
                  cancel_lim_q <= was_out_q ? CNT_W'(CANCEL_OUT)
                                            : CNT_W'(CANCEL_IN);
                  if (was_out_q && tmr_q < CNT_W'(BLANK)) begin
                     st_q <= ST_BLANK;
                  end else begin
                     tmr_q <= '0;
                     st_q  <= ST_LOAD;
                  end
               end
            end
            // Blanking cut short so the reload still fits the bound
            ST_BLANK: begin
               tmr_q <= tmr_q + 1'b1;
               if (tmr_q >= CNT_W'(BLANK) || cancel_cnt_q >= load_start) begin
                  tmr_q <= '0;
                  st_q  <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               tmr_q <= tmr_q + 1'b1;
               // short lows during reload filtered too
               if (accept) begin
                  was_out_q <= sleep_out_i;
                  tmr_q     <= '0;
                  st_q      <= ST_LOW;
               end else if (tmr_q >= CNT_W'(LOAD)) begin
                  st_q <= ST_DEFAULT;
               end
            end
            ST_DEFAULT: begin
               if (accept) begin
                  was_out_q <= sleep_out_i;
                  tmr_q     <= '0;
                  st_q      <= ST_LOW;
               end else if (cancel_cnt_q >= cancel_end) begin
                  st_q <= ST_RUN;
               end
            end
            default: st_q <= ST_RUN;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         core_reset_o  <= 1'b0;
         blank_o       <= 1'b0;
         nvm_load_o    <= 1'b0;
         cancel_busy_o <= 1'b0;
         ready_o       <= 1'b1;
      end else begin
         core_reset_o  <= (st_q == ST_LOW) || (st_q == ST_BLANK);
         blank_o       <= (st_q != ST_RUN);
         nvm_load_o    <= (st_q == ST_LOAD);
         cancel_busy_o <= (st_q == ST_BLANK) || (st_q == ST_LOAD)
                          || (st_q == ST_DEFAULT);
         ready_o       <= (st_q == ST_RUN) && !accept;
      end
   end

   short_reject_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (st_q == ST_RUN && !accept) |=> st_q != ST_LOW)
      else $error("Reset taken before threshold");

   low_count_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (filt_low_q && low_cnt_q < CNT_W'(LOW_THR))
      |=> low_cnt_q == $past(low_cnt_q) + 1'b1)
      else $error("Low counter did not advance");

   low_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (!filt_low_q) |=> low_cnt_q == '0)
      else $error("Low counter not cleared");

   glitch_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (filt_low_q && pin_s2_q && glitch_q < CNT_W'(GLITCH)) |=> filt_low_q)
      else $error("Glitch ended the low period");

   load_after_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (st_q == ST_LOAD && !filt_low_q) |=> st_q inside {ST_LOAD, ST_DEFAULT})
      else $error("Load step skipped");

   blank_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (st_q == ST_LOW) |=> blank_o)
      else $error("Display not blanked in reset");

   cancel_lim_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (st_q == ST_DEFAULT && !was_out_q)
      |-> cancel_lim_q == CNT_W'(CANCEL_IN))
      else $error("Wrong cancel limit for sleep-in");

   blank_bound_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (st_q == ST_BLANK) |-> tmr_q <= CNT_W'(BLANK))
      else $error("Blanking exceeded limit");

   ready_out_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (st_q == ST_LOAD) |=> !ready_o)
      else $error("Ready during reload");

   cancel_bound_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (st_q inside {ST_BLANK, ST_LOAD, ST_DEFAULT})
      |-> cancel_cnt_q <= cancel_end)
      else $error("Reset cancel ran past its limit");
endmodule : display_hw_reset_sequencer

// ---- display_hw_reset_sequencer_tb_top.sv ----
// Testbench for the hardware reset sequencer
`timescale 1ns/100ps
module display_hw_reset_sequencer_tb_top;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic sleep_out_i = 1'b0;
   logic pin_n;
   logic core_reset_o, blank_o, nvm_load_o, cancel_busy_o, ready_o;
   logic s_rst, s_load, s_blank, s_busy;
   logic clr = 1'b0;
   logic rst_prev = 1'b0;
   int   n_fail = 0;
   int   checks = 0;
   int   n_rise = 0;
   always #2.5 mclk_i = ~mclk_i;
   host_reset_model host_reset_model_i (.mclk_i(mclk_i),
      .hw_reset_in_n_o(pin_n));
   display_hw_reset_sequencer #(.LOW_THR(50), .GLITCH(4),
      .CANCEL_IN(200), .CANCEL_OUT(400), .BLANK(100))
      display_hw_reset_sequencer_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .hw_reset_in_n_i(pin_n), .sleep_out_i(sleep_out_i),
      .core_reset_o(core_reset_o), .blank_o(blank_o),
      .nvm_load_o(nvm_load_o), .cancel_busy_o(cancel_busy_o),
      .ready_o(ready_o));
   // Sticky flags, cleared at the start of each run
   always @(posedge mclk_i) begin
      if (clr) begin
         {s_rst, s_load, s_blank, s_busy} <= 4'h0;
         n_rise <= 0;
      end else begin
         s_rst   <= s_rst | core_reset_o;
         s_load  <= s_load | nvm_load_o;
         s_blank <= s_blank | blank_o;
         s_busy  <= s_busy | cancel_busy_o;
         if (core_reset_o && !rst_prev) n_rise <= n_rise + 1;
      end
      rst_prev <= core_reset_o;
   end
   task automatic check(input string nm, input logic seen, input logic exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %b seen %b", nm, exp, seen);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : conclude
   // One pin pulse, then judge what followed it
   task automatic run(input string nm, input int low, input int gl,
                      input logic slp, input logic hit, input int lim);
      int n;
      @(negedge mclk_i);
      sleep_out_i = slp;
      clr = 1'b1;
      @(negedge mclk_i);
      clr = 1'b0;
      host_reset_model_i.pulse(low, gl);
      n = 0;
      while (ready_o !== 1'b1 && n <= lim) begin
         @(negedge mclk_i);
         n++;
      end
      repeat (4) @(negedge mclk_i);
      check("ready", ready_o, 1'b1);
      check("in time", n <= lim, 1'b1);
      check("core_reset", s_rst, hit);
      check("nvm_load", s_load, hit);
      check("blank", s_blank, hit);
      check("busy", s_busy, hit);
      check("one reset", n_rise == 1, hit);
      $display("test %s done", nm);
   endtask : run
   // Block reset in mid-cancel returns outputs to idle
   task automatic mid_reset();
      @(negedge mclk_i);
      sleep_out_i = 1'b1;
      host_reset_model_i.pulse(80, -10);
      repeat (20) @(negedge mclk_i);
      check("busy before", cancel_busy_o, 1'b1);
      check("blank before", blank_o, 1'b1);
      rst_n_i = 1'b0;
      repeat (2) @(negedge mclk_i);
      rst_n_i = 1'b1;
      @(negedge mclk_i);
      check("reset ready", ready_o, 1'b1);
      check("reset blank", blank_o, 1'b0);
      check("reset core", core_reset_o, 1'b0);
      check("reset busy", cancel_busy_o, 1'b0);
      $display("test mid_reset done");
   endtask : mid_reset
   initial begin
      repeat (8) @(negedge mclk_i);
      rst_n_i = 1'b1;
      repeat (4) @(negedge mclk_i);
      check("idle ready", ready_o, 1'b1);
      check("idle blank", blank_o, 1'b0);
      run("short", 30, -10, 1'b0, 1'b0, 0);
      run("near", 45, 20, 1'b1, 1'b0, 0);
      run("sleep_in", 80, 65, 1'b0, 1'b1, 200);
      run("sleep_out", 80, -10, 1'b1, 1'b1, 400);
      run("again_in", 60, 55, 1'b0, 1'b1, 200);
      mid_reset();
      run("after_rst", 60, -10, 1'b0, 1'b1, 200);
      conclude();
   end
   // Watchdog well past the expected run length
   initial begin
      #50000;
      n_fail++;
      conclude();
   end
endmodule : display_hw_reset_sequencer_tb_top

// ---- host_reset_model.sv ----
// Host model driving the hardware reset pin
`timescale 1ns/100ps
module host_reset_model (
   // Clock
   input  wire logic mclk_i,
   // Reset pin
   output logic      hw_reset_in_n_o
);
   initial hw_reset_in_n_o = 1'b1;
   task automatic pulse(input int low_cyc, input int gl_at);
      for (int i = 0; i < low_cyc; i++) begin
         @(negedge mclk_i);
         hw_reset_in_n_o <= (i >= gl_at && i < gl_at + 2);
      end
      @(negedge mclk_i);
      hw_reset_in_n_o <= 1'b1;
   endtask : pulse
endmodule : host_reset_model

// ---- rst_seq_pkg.sv ----
// Constants and timing for the display hardware reset sequencer
// Summary of operation
// - Low pulses under 5 us ignored; over 9 us reset, except a pulse that ends during sleep-out blanking
// - Short glitches inside a valid low pulse do not disturb the reset
// - Each rising edge of reset reloads identity and settings from storage
// - Reset cancel ends within 5 ms in sleep-in, 120 ms in sleep-out
// - Reset in sleep-out blanks the display, blanking at most 120 ms
// - Reset in sleep-in keeps display blank; then restore reset defaults
package rst_seq_pkg;
   localparam int unsigned CLK_MHZ        = 200;
   localparam int unsigned REJECT_US      = 5;
   localparam int unsigned ACCEPT_US      = 9;
   localparam int unsigned GLITCH_NS      = 1000;
   localparam int unsigned CANCEL_IN_MS   = 5;
   localparam int unsigned CANCEL_OUT_MS  = 120;
   localparam int unsigned BLANK_MS       = 120;
   // Threshold placed between the reject and accept limits
   localparam int unsigned LOW_THR_CYC    =
      ((REJECT_US + ACCEPT_US) / 2) * CLK_MHZ;
   localparam int unsigned GLITCH_CYC     = GLITCH_NS * CLK_MHZ / 1000;
   localparam int unsigned CANCEL_IN_CYC  = CANCEL_IN_MS * 1000 * CLK_MHZ;
   localparam int unsigned CANCEL_OUT_CYC = CANCEL_OUT_MS * 1000 * CLK_MHZ;
   localparam int unsigned BLANK_CYC      = BLANK_MS * 1000 * CLK_MHZ;
   localparam int unsigned LOAD_CYC       = 64;
   localparam int unsigned CNT_W          = 25;
   typedef enum logic [2:0] {
      ST_RUN, ST_LOW, ST_BLANK, ST_LOAD, ST_DEFAULT
   } seq_state_t;
endpackage : rst_seq_pkg
